// [hw/dah_regs.vh]
// Constants for the drive alarm handler
// What this block does
// - Homed travel limit raises mechanical overtravel alarm
// - Over-limit speed/current or disabled wrap raises data alarm
// - Bad gear resolution alarm, power cycle clears
// - Wrap/gear conflict at power-up, power cycle clears
// - Bus error or non-operational state while operating raises alarm
// - Network module fault alarm, power cycle clears
// - Following error window, 1..30000, default 300
// - AC motor or small motor at 48V alarms
// - Any alarm drops outputs and removes excitation
// - Clear input with cause gone clears alarm, except gear, wrap and module alarms
// - Excite command at clear excites and sets command ready; ready output only while motion is not busy
`ifndef DAH_REGS_VH
`define DAH_REGS_VH
`define DAH_OFS_OVERLOAD_TIME 16'h4180
`define DAH_OFS_FOLLOW_ERR 16'h6065
`define DAH_RST_OVERLOAD_TIME 16'h0032
`define DAH_RST_FOLLOW_ERR 32'h0000012c
`define DAH_MIN_OVERLOAD_TIME 16'h0001
`define DAH_MAX_OVERLOAD_TIME 16'h012c
`define DAH_MIN_FOLLOW_ERR 32'h00000001
`define DAH_MAX_FOLLOW_ERR 32'h00007530
`define DAH_CODE_COMBINATION 8'h45
`define DAH_CODE_MECH_OVERTRAVEL 8'h6d
`define DAH_CODE_OP_DATA 8'h70
`define DAH_CODE_GEAR 8'h71
`define DAH_CODE_WRAP 8'h72
`define DAH_CODE_NET_BUS 8'h81
`define DAH_CODE_NET_MODULE 8'h82
`define DAH_NUM_ALARMS 7
`endif

// [hw/dah_alarm_latch.v]
// Sticky alarm latch with selectable clear path
`timescale 1ns/1ps
module dah_alarm_latch #(
	parameter N = 7
) (
	input wire core_clk,
	input wire rst_b,
	input wire [N-1:0] cause,
	input wire [N-1:0] resettable,
	input wire clearPulse,
	output reg [N-1:0] latched
);
	integer i;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			latched <= {N{1'b0}};
		end else begin
			for (i = 0; i < N; i = i + 1) begin
				// Live cause wins over a clear
				if (cause[i])
					latched[i] <= 1'b1;
				else if (clearPulse && resettable[i])
					latched[i] <= 1'b0;
			end
		end
	end
endmodule // dah_alarm_latch

// [hw/dah_alarm_handler.v]
// Drive alarm handler top: causes, latch, clear handshake, settings
`timescale 1ns/1ps
`include "dah_regs.vh"
module dah_alarm_handler (
	input wire core_clk,
	input wire rst_b,
	input wire homed,
	input wire atMechLimit,
	input wire overProtectLimit,
	input wire wrapOpStart,
	input wire wrapEnabled,
	input wire gearResolutionBad,
	input wire powerUpCheck,
	input wire wrapGearConflict,
	input wire operating,
	input wire fieldbusCommError,
	input wire fieldbusOperational,
	input wire netModuleFault,
	input wire motorIsAc,
	input wire motorSmallFrame,
	input wire supply48v,
	input wire alarm_clear_in,
	input wire exciteCmd,
	input wire motionBusy,
	input wire regWrite,
	input wire [15:0] regIndex,
	input wire [31:0] regWdata,
	output reg [31:0] regRdata,
	output reg regError,
	output reg alarm_ok_out,
	output reg motionActiveOut,
	output reg drive_command_ready_out,
	output reg readyOut,
	output reg exciteOut,
	output reg motorStop,
	output reg [7:0] alarmCode,
	output reg [15:0] overloadTimeLimit,
	output reg [31:0] followingErrorLimit
);
	localparam N = `DAH_NUM_ALARMS;
	reg clearPrev;
	wire [N-1:0] latched;
	wire [N-1:0] cause;
	wire clearPulse;
	wire anyAlarm;
	reg [7:0] next_code;
	reg next_alarmOk;
	reg next_motionActive;
	reg next_driveCmdReady;
	reg next_ready;
	reg next_excite;
	reg next_motorStop;
	reg [31:0] next_regRdata;
	reg next_regError;
	reg [15:0] next_overloadTime;
	reg [31:0] next_followErr;
	wire hitOverload;
	wire hitFollow;
	wire okOverload;
	wire okFollow;

	// Shared limit test for both settings
	function inLimits;
		input [31:0] value;
		input [31:0] lo;
		input [31:0] hi;
		begin
			inLimits = (value >= lo) && (value <= hi);
		end
	endfunction

	// Bit order: combination, overtravel, data, gear, wrap, bus, module
	assign cause[0] = motorIsAc | (motorSmallFrame & supply48v);
	assign cause[1] = homed & atMechLimit;
	assign cause[2] = overProtectLimit | (wrapOpStart & ~wrapEnabled);
	assign cause[3] = gearResolutionBad;
	assign cause[4] = powerUpCheck & wrapGearConflict;
	assign cause[5] = operating & (fieldbusCommError | ~fieldbusOperational);
	assign cause[6] = netModuleFault;

	// Gear, wrap and module alarms ignore the clear input; only power-on reset ends them
	localparam [N-1:0] RESETTABLE = 7'b0100111;

	// Edge only, so a held input cannot re-clear later alarms
	assign clearPulse = alarm_clear_in & ~clearPrev;

	dah_alarm_latch #(.N(N)) uLatch (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.cause(cause),
		.resettable(RESETTABLE),
		.clearPulse(clearPulse),
		.latched(latched)
	);

	assign anyAlarm = |latched;

	always @* begin
		next_code = 8'h00;
		if (latched[0]) next_code = `DAH_CODE_COMBINATION;
		else if (latched[1]) next_code = `DAH_CODE_MECH_OVERTRAVEL;
		else if (latched[2]) next_code = `DAH_CODE_OP_DATA;
		else if (latched[3]) next_code = `DAH_CODE_GEAR;
		else if (latched[4]) next_code = `DAH_CODE_WRAP;
		else if (latched[5]) next_code = `DAH_CODE_NET_BUS;
		else if (latched[6]) next_code = `DAH_CODE_NET_MODULE;
	end

	// Alarm forces the safe state; otherwise outputs follow the excite command
	always @* begin
		next_alarmOk = 1'b0;
		next_motionActive = 1'b0;
		next_driveCmdReady = 1'b0;
		next_ready = 1'b0;
		next_excite = 1'b0;
		next_motorStop = 1'b1;
		if (anyAlarm) begin
			next_alarmOk = 1'b0;
			next_motionActive = 1'b0;
			next_driveCmdReady = 1'b0;
			next_ready = 1'b0;
			next_excite = 1'b0;
			next_motorStop = 1'b1;
		end else begin
			next_alarmOk = 1'b1;
			next_excite = exciteCmd;
			next_ready = exciteCmd & ~motionBusy;
			next_driveCmdReady = exciteCmd;
			next_motionActive = exciteCmd & motionBusy;
			next_motorStop = ~exciteCmd;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clearPrev <= 1'b0;
			alarm_ok_out <= 1'b0;
			motionActiveOut <= 1'b0;
			drive_command_ready_out <= 1'b0;
			readyOut <= 1'b0;
			exciteOut <= 1'b0;
			motorStop <= 1'b1;
			alarmCode <= 8'h00;
		end else begin
			clearPrev <= alarm_clear_in;
			alarmCode <= next_code;
			alarm_ok_out <= next_alarmOk;
			motionActiveOut <= next_motionActive;
			drive_command_ready_out <= next_driveCmdReady;
			readyOut <= next_ready;
			exciteOut <= next_excite;
			motorStop <= next_motorStop;
		end
	end

	assign hitOverload = (regIndex == `DAH_OFS_OVERLOAD_TIME);
	assign hitFollow = (regIndex == `DAH_OFS_FOLLOW_ERR);
	// Full 32-bit compare, so stray upper bits also refuse the write
	assign okOverload = inLimits(regWdata, {16'h0000, `DAH_MIN_OVERLOAD_TIME},
		{16'h0000, `DAH_MAX_OVERLOAD_TIME});
	assign okFollow = inLimits(regWdata, `DAH_MIN_FOLLOW_ERR, `DAH_MAX_FOLLOW_ERR);

	// Settings; out-of-range writes are refused and flagged, value kept
	always @* begin
		next_overloadTime = overloadTimeLimit;
		next_followErr = followingErrorLimit;
		next_regRdata = {24'h000000, alarmCode};
		next_regError = 1'b0;
		if (hitOverload) begin
			next_regRdata = {16'h0000, overloadTimeLimit};
			if (regWrite) begin
				if (okOverload)
					next_overloadTime = regWdata[15:0];
				else
					next_regError = 1'b1;
			end
		end else if (hitFollow) begin
			next_regRdata = followingErrorLimit;
			if (regWrite) begin
				if (okFollow)
					next_followErr = regWdata;
				else
					next_regError = 1'b1;
			end
		end else begin
			// Unmapped reads show the active code, writes there are refused
			next_regError = regWrite;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			overloadTimeLimit <= `DAH_RST_OVERLOAD_TIME;
			followingErrorLimit <= `DAH_RST_FOLLOW_ERR;
			regRdata <= 32'h00000000;
			regError <= 1'b0;
		end else begin
			overloadTimeLimit <= next_overloadTime;
			followingErrorLimit <= next_followErr;
			regRdata <= next_regRdata;
			regError <= next_regError;
		end
	end
endmodule // dah_alarm_handler

// [tb/dah_alarm_checker.sv]
// Port-level checks for the alarm handler
`timescale 1ns/1ps
module dah_alarm_checker (
	input wire core_clk, rst_b, homed, atMechLimit, motorIsAc, motorSmallFrame, supply48v,
	input wire operating, fieldbusCommError, fieldbusOperational, alarm_clear_in, exciteCmd,
	input wire regWrite, regError, alarm_ok_out, exciteOut, drive_command_ready_out,
	input wire [15:0] regIndex, overloadTimeLimit,
	input wire [31:0] regWdata, followingErrorLimit,
	input wire [7:0] alarmCode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_MECH: assert property (homed && atMechLimit |-> ##2
		!alarm_ok_out && !exciteOut && !drive_command_ready_out) else $error("overtravel kept outputs");
	AST_COMBO: assert property (motorIsAc || motorSmallFrame && supply48v
		|-> ##2 alarmCode == 8'h45) else $error("combination code missing");
	AST_BUS: assert property (operating && (fieldbusCommError || !fieldbusOperational)
		|-> ##2 !alarm_ok_out) else $error("bus fault ignored");
	AST_MOD: assert property (alarmCode == 8'h82 |=> !alarm_ok_out) else $error("module alarm cleared");
	// Reset history excluded: the first rise after release is no clear
	AST_CLR: assert property ($rose(alarm_ok_out) && $past(rst_b) && $past(rst_b, 2) && $past(rst_b, 3)
		|-> $past(alarm_clear_in, 2) && !$past(alarm_clear_in, 3)) else $error("clear without rise");
	AST_EXC: assert property ($rose(alarm_ok_out) && $past(exciteCmd)
		|-> exciteOut && drive_command_ready_out) else $error("no excitation at clear");
	AST_OVL: assert property (regWrite && regIndex == 16'h4180 && (regWdata == 0 || regWdata > 300)
		|=> regError && $stable(overloadTimeLimit)) else $error("bad overload write taken");
	AST_FOL: assert property (regWrite && regIndex == 16'h6065 && regWdata != 0 && regWdata <= 30000
		|=> !regError && followingErrorLimit == $past(regWdata)) else $error("window write lost");
endmodule // dah_alarm_checker
bind dah_alarm_handler dah_alarm_checker i_chk (.*);

// [tb/dah_master_model.sv]
// Controlling master: stops motion, then runs the clear handshake
`timescale 1ns/1ps
module dah_master_model (
	input wire core_clk,
	input wire go,
	input wire alarm_ok_out,
	output reg alarm_clear_in = 0,
	output reg motionBusy = 1
);
	always @(posedge go) begin
		@(posedge core_clk) #1 motionBusy = 0;
		@(posedge core_clk) #1 alarm_clear_in = 1;
		// Bounded, since sticky alarms never answer
		repeat (6) begin
			@(posedge core_clk) #1;
			if (alarm_ok_out === 1'b1) break;
		end
		alarm_clear_in = 0;
	end
endmodule // dah_master_model

// [tb/testbench.sv]
// Register and alarm sequence tests for the alarm handler
`timescale 1ns/1ps
module testbench;
	reg core_clk = 0, rst_b = 0, homed = 1, operating = 1, powerUpCheck = 1, wrapEnabled = 0;
	reg exciteCmd = 1, motorIsAc = 0, motorSmallFrame = 0, supply48v = 0, atMechLimit = 0;
	reg overProtectLimit = 0, wrapOpStart = 0, gearResolutionBad = 0, wrapGearConflict = 0;
	reg fieldbusCommError = 0, fbDown = 0, netModuleFault = 0, regWrite = 0, go = 0;
	reg [15:0] regIndex = 0;
	reg [31:0] regWdata = 0;
	wire fieldbusOperational = !fbDown;
	wire alarm_clear_in, motionBusy, regError, alarm_ok_out, motionActiveOut, readyOut;
	wire drive_command_ready_out, exciteOut, motorStop;
	wire [31:0] regRdata, followingErrorLimit;
	wire [15:0] overloadTimeLimit;
	wire [7:0] alarmCode;
	int n_mismatch = 0, tests_run = 0, i;
	reg [10:0] cause [10] = '{11'h400, 11'h300, 11'h080, 11'h040, 11'h020, 11'h010, 11'h008,
		11'h004, 11'h002, 11'h001};
	reg [7:0] code [10] = '{8'h45, 8'h45, 8'h6d, 8'h70, 8'h70, 8'h71, 8'h72, 8'h81, 8'h81, 8'h82};
	reg [9:0] stick = 10'h260;
	dah_alarm_handler i_dah_alarm_handler (.*);
	dah_master_model i_dah_master_model (.*);
	initial forever #50 core_clk = ~core_clk;
	task chk(input [31:0] seen, input [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t %h %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task reset_dut;
		rst_b = 0;
		repeat (20) @(posedge core_clk);
		#1 rst_b = 1;
	endtask
	task wr(input [15:0] a, input [31:0] d, input e);
		@(posedge core_clk) #1 regWrite = 1;
		regIndex = a;
		regWdata = d;
		@(posedge core_clk) #1 regWrite = 0;
		chk(regError, e);
	endtask
	task rd(input [15:0] a, input [31:0] e);
		@(posedge core_clk) #1 regIndex = a;
		@(posedge core_clk) #1 chk(regRdata, e);
	endtask
	task setc(input [10:0] v);
		{motorIsAc, motorSmallFrame, supply48v, atMechLimit, overProtectLimit, wrapOpStart,
			gearResolutionBad, wrapGearConflict, fieldbusCommError, fbDown, netModuleFault} = v;
	endtask
	initial begin
		#1000000 n_mismatch++;
		tally_and_finish;
	end
	initial begin
		reset_dut;
		rd(16'h4180, 32'h32);
		rd(16'h6065, 32'h12c);
		wr(16'h4180, 32'h12d, 1);
		wr(16'h4180, 32'h12c, 0);
		wr(16'h4180, 32'h0, 1);
		rd(16'h4180, 32'h12c);
		wr(16'h6065, 32'h7531, 1);
		wr(16'h6065, 32'h1, 0);
		wr(16'h1234, 32'h5, 1);
		rd(16'h6065, 32'h1);
		{homed, operating, powerUpCheck, wrapEnabled} = 4'b0001;
		setc(11'h0ae);
		repeat (3) @(posedge core_clk);
		#1 chk({alarm_ok_out, alarmCode}, 9'h100);
		{homed, operating, powerUpCheck, wrapEnabled} = 4'b1110;
		for (i = 0; i < 10; i++) begin
			exciteCmd = i[0];
			setc(cause[i]);
			repeat (3) @(posedge core_clk);
			#1 chk({alarm_ok_out, exciteOut, drive_command_ready_out, motionActiveOut, motorStop}, 1);
			chk(alarmCode, code[i]);
			setc(0);
			go = 1;
			@(posedge core_clk) #1 go = 0;
			repeat (12) @(posedge core_clk);
			#1 chk({alarm_ok_out, exciteOut}, {!stick[i], !stick[i] && exciteCmd});
			chk({readyOut, drive_command_ready_out, motionActiveOut, motorStop}, {!stick[i] && exciteCmd, !stick[i] && exciteCmd, 1'b0, stick[i] || !exciteCmd});
			if (stick[i]) reset_dut;
		end
		tally_and_finish;
	end
endmodule // testbench
